// file: torque_ref_defs.svh
// Constants of the torque reference conditioning block.
// Assumes a 10 MHz core clock and a register port with 16-bit data.
`ifndef TORQUE_REF_DEFS_SVH
`define TORQUE_REF_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define REG_CTRL_MODE    8'h00
`define REG_SRC_SELECT   8'h04
`define REG_GAIN         8'h08
`define REG_FILTER_TC    8'h0c
`define REG_FUNCTION     8'h10
`define REG_OFFSET       8'h14
`define REG_STATUS       8'h18
`define REG_TORQUE       8'h1c

// ****************************************
// Reset values and limits
// ****************************************
`define CTRL_MODE_RESET  4'h0
`define CTRL_MODE_TORQUE 4'h2
`define SRC_ANALOG       1'h0
`define GAIN_RESET       16'h0021
`define GAIN_MIN         16'h000a
`define GAIN_MAX         16'h0064
`define TC_RESET         16'h0032
`define TC_MAX           16'h09c4
`define OFFSET_MIN       16'hfc00
`define OFFSET_MAX       16'h0400
`define TORQUE_SCALE     24'h00000a

// ****************************************
// Function numbers
// ****************************************
`define FN_EXIT          8'h00
`define FN_RESTORE       8'h01
`define FN_AUTO_OFFSET   8'h03
`define FN_MANUAL_OFFSET 8'h04
`define FN_RESTART       8'hf0

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS    100
`define FILT_TICK_NS     10000
`define FILT_TICK_CYC    (`FILT_TICK_NS / `CLK_PERIOD_NS)
`define KEY_HOLD_MS      1000
`define KEY_HOLD_CYC     (`KEY_HOLD_MS * (1000000 / `CLK_PERIOD_NS))
`define CAL_SAMPLES_LOG2 4

`endif

// file: torque_ref_pkg.sv
// Types shared by the torque reference conditioning design.
// Assumes torque_ref_defs.svh holds the numeric constants.
package torque_ref_pkg;

  typedef logic signed [15:0] sample_type;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0001,
    ST_AUTO     = 4'b0010,
    ST_MAN_SEL  = 4'b0100,
    ST_MAN_EDIT = 4'b1000
  } cal_state_type;

endpackage

// file: seq_divider.sv
// Sequential signed-by-unsigned restoring divider, one bit a cycle.
// Assumes the divisor is non-zero and held only at the start pulse.
`timescale 1ns/1ps
module seq_divider #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_sys_rst,
  // Request
  input  wire logic                i_start,
  input  wire logic signed [W-1:0] i_num,
  input  wire logic        [W-1:0] i_den,
  // Answer
  output logic                     o_busy,
  output logic                     o_done,
  output logic signed [W-1:0]      o_quot
);
  localparam int CW = $clog2(W + 1);

  logic          busy_ff, nxt_busy, done_ff, nxt_done, neg_ff, nxt_neg;
  logic [W-1:0]  rem_ff, nxt_rem, quo_ff, nxt_quo, den_ff, nxt_den;
  logic [W-1:0]  res_ff, nxt_res;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [W:0]    shifted, trial;

  always_comb begin
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_neg  = neg_ff;
    nxt_rem  = rem_ff;
    nxt_quo  = quo_ff;
    nxt_den  = den_ff;
    nxt_res  = res_ff;
    nxt_cnt  = cnt_ff;
    shifted  = {rem_ff, quo_ff[W-1]};
    trial    = shifted - {1'b0, den_ff};
    if (i_start && !busy_ff) begin
      nxt_busy = 1'b1;
      nxt_neg  = i_num[W-1];
      nxt_quo  = i_num[W-1] ? W'(-i_num) : W'(i_num);
      nxt_rem  = '0;
      nxt_den  = i_den;
      nxt_cnt  = CW'(W);
    end else if (busy_ff) begin
      nxt_quo = {quo_ff[W-2:0], ~trial[W]};
      nxt_rem = trial[W] ? shifted[W-1:0] : trial[W-1:0];
      nxt_cnt = cnt_ff - CW'(1);
      if (cnt_ff == CW'(1)) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        nxt_res  = neg_ff ? W'(-nxt_quo) : nxt_quo;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      neg_ff  <= 1'b0;
      rem_ff  <= '0;
      quo_ff  <= '0;
      den_ff  <= '0;
      res_ff  <= '0;
      cnt_ff  <= '0;
    end else begin
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      neg_ff  <= nxt_neg;
      rem_ff  <= nxt_rem;
      quo_ff  <= nxt_quo;
      den_ff  <= nxt_den;
      res_ff  <= nxt_res;
      cnt_ff  <= nxt_cnt;
    end
  end

  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_quot = res_ff;
endmodule

// file: torque_reference_conditioning.sv
// Torque reference conditioning: offset removal, gain, lag filter,
// auto and manual offset calibration, register port.
// Assumes a digitised differential input in mV on the core clock and
// an external non-volatile store that presents the saved offset.
`timescale 1ns/1ps
`include "torque_ref_defs.svh"
module torque_reference_conditioning #(
  parameter int HOLD_CYCLES = `KEY_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_sys_rst,
  // Register port
  input  wire logic [7:0]               i_reg_addr,
  input  wire logic [15:0]              i_reg_wdata,
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  output logic [15:0]                   o_reg_rdata,
  // Digitised torque reference, mV
  input  wire torque_ref_pkg::sample_type i_adc_sample,
  input  wire logic                     i_adc_valid,
  // Panel keys and servo-on pin
  input  wire logic                     i_key_mode,
  input  wire logic                     i_key_up,
  input  wire logic                     i_key_down,
  input  wire logic                     i_key_return,
  input  wire logic                     i_servo_on,
  // Non-volatile offset store
  input  wire torque_ref_pkg::sample_type i_nv_offset,
  output logic                          o_nv_wr,
  output torque_ref_pkg::sample_type    o_nv_data,
  // Torque command and display
  output torque_ref_pkg::sample_type    o_torque_cmd,
  output logic                          o_torque_valid,
  output logic                          o_torque_active,
  output logic                          o_offset_shown,
  output torque_ref_pkg::sample_type    o_disp_offset
);
  import torque_ref_pkg::*;

  localparam int HW = 24;
  localparam int TW = $clog2(`FILT_TICK_CYC);
  localparam int CL = `CAL_SAMPLES_LOG2;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] meta_ff, sync_ff;
  logic [4:0] prev_ff;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= {i_servo_on, i_key_return, i_key_down, i_key_up,
                  i_key_mode};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end
  logic key_mode, key_ret, servo_on, up_edge, down_edge, ret_edge;
  assign key_mode  = sync_ff[0];
  assign key_ret   = sync_ff[3];
  assign servo_on  = sync_ff[4];
  assign up_edge   = sync_ff[1] & ~prev_ff[1];
  assign down_edge = sync_ff[2] & ~prev_ff[2];
  assign ret_edge  = sync_ff[3] & ~prev_ff[3];

  function automatic sample_type clamp_offset(input logic signed [19:0] v);
    if (v < 20'(signed'(`OFFSET_MIN)))
      return `OFFSET_MIN;
    else if (v > 20'(signed'(`OFFSET_MAX)))
      return `OFFSET_MAX;
    else
      return v[15:0];
  endfunction

  // ****************************************
  // Register file and calibration control
  // ****************************************
  logic [3:0]        mode_pend_ff, nxt_mode_pend, mode_act_ff, nxt_mode_act;
  logic              src_ff, nxt_src;
  logic [15:0]       gain_ff, nxt_gain, tc_ff, nxt_tc;
  logic [15:0]       rdata_ff, nxt_rdata;
  cal_state_type     st_ff, nxt_st;
  sample_type        off_ff, nxt_off;
  logic              loaded_ff, nxt_loaded;
  logic              nvwr_ff, nxt_nvwr, active_ff, nxt_active;
  logic signed [19:0] acc_ff, nxt_acc;
  logic [CL:0]       ncal_ff, nxt_ncal;
  logic [23:0]       hold_ff, nxt_hold;
  logic              hold_key, hold_fire, fn_wr;
  sample_type        torque_ff;

  assign fn_wr = i_reg_wr && (i_reg_addr == `REG_FUNCTION);

  always_comb begin
    nxt_mode_pend = mode_pend_ff;
    nxt_mode_act  = mode_act_ff;
    nxt_src       = src_ff;
    nxt_gain      = gain_ff;
    nxt_tc        = tc_ff;
    nxt_rdata     = 16'h0000;
    nxt_st        = st_ff;
    nxt_off       = off_ff;
    nxt_loaded    = 1'b1;
    nxt_nvwr      = 1'b0;
    nxt_acc       = acc_ff;
    nxt_ncal      = ncal_ff;
    hold_key      = (st_ff == ST_MAN_SEL)  ? key_mode :
                    (st_ff == ST_MAN_EDIT) ? key_ret : 1'b0;
    hold_fire = hold_key && (hold_ff == 24'(HOLD_CYCLES - 1));
    nxt_hold  = !hold_key ? 24'h000000 :
                (hold_ff == 24'(HOLD_CYCLES)) ? hold_ff : hold_ff + 24'h1;
    // saved offset restored once after reset
    if (!loaded_ff)
      nxt_off = clamp_offset(20'(i_nv_offset));
    if (i_reg_wr) begin
      case (i_reg_addr)
        `REG_CTRL_MODE:  nxt_mode_pend = i_reg_wdata[3:0];
        // source select takes effect at once
        `REG_SRC_SELECT: nxt_src = i_reg_wdata[0];
        `REG_GAIN:
          nxt_gain = (i_reg_wdata < `GAIN_MIN) ? `GAIN_MIN :
                     (i_reg_wdata > `GAIN_MAX) ? `GAIN_MAX : i_reg_wdata;
        `REG_FILTER_TC:
          nxt_tc = (i_reg_wdata > `TC_MAX) ? `TC_MAX : i_reg_wdata;
        default: ;
      endcase
    end
    if (fn_wr) begin
      case (i_reg_wdata[7:0])
        // mode change applies only on restart
        `FN_RESTART: nxt_mode_act = mode_pend_ff;
        // factory restore leaves the offset alone
        `FN_RESTORE: begin
          nxt_mode_pend = `CTRL_MODE_RESET;
          nxt_src       = `SRC_ANALOG;
          nxt_gain      = `GAIN_RESET;
          nxt_tc        = `TC_RESET;
        end
        default: ;
      endcase
    end
    case (st_ff)
      ST_IDLE: begin
        // auto start refused while servo on
        if (fn_wr && i_reg_wdata[7:0] == `FN_AUTO_OFFSET && !servo_on) begin
          nxt_st   = ST_AUTO;
          nxt_acc  = '0;
          nxt_ncal = '0;
        end else if (fn_wr && i_reg_wdata[7:0] == `FN_MANUAL_OFFSET) begin
          nxt_st = ST_MAN_SEL;
        end
      end
      ST_AUTO: begin
        // average residual, store and apply it
        if (i_adc_valid) begin
          nxt_acc  = acc_ff + 20'(i_adc_sample);
          nxt_ncal = ncal_ff + (CL+1)'(1);
        end
        if (ncal_ff[CL]) begin
          nxt_off  = clamp_offset(acc_ff >>> CL);
          nxt_nvwr = 1'b1;
          nxt_st   = ST_IDLE;
        end
      end
      ST_MAN_SEL: begin
        // one-second mode hold opens the edit
        // edit opens only in servo-on state
        if (hold_fire && servo_on)
          nxt_st = ST_MAN_EDIT;
        else if (ret_edge || (fn_wr && i_reg_wdata[7:0] == `FN_EXIT))
          nxt_st = ST_IDLE;
      end
      ST_MAN_EDIT: begin
        if (up_edge && !down_edge)
          nxt_off = clamp_offset(20'(off_ff) + 20'sd1);
        else if (down_edge && !up_edge)
          nxt_off = clamp_offset(20'(off_ff) - 20'sd1);
        // one-second return hold leaves the edit
        if (hold_fire) begin
          nxt_nvwr = 1'b1;
          nxt_st   = ST_MAN_SEL;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    if (i_reg_rd) begin
      case (i_reg_addr)
        `REG_CTRL_MODE:  nxt_rdata = {12'h000, mode_pend_ff};
        `REG_SRC_SELECT: nxt_rdata = {15'h0000, src_ff};
        `REG_GAIN:       nxt_rdata = gain_ff;
        `REG_FILTER_TC:  nxt_rdata = tc_ff;
        `REG_OFFSET:     nxt_rdata = off_ff;
        `REG_STATUS:     nxt_rdata = {7'h00, servo_on, st_ff, mode_act_ff};
        `REG_TORQUE:     nxt_rdata = torque_ff;
        default:         nxt_rdata = 16'h0000;
      endcase
    end
    nxt_active = (nxt_mode_act == `CTRL_MODE_TORQUE) && (nxt_src == `SRC_ANALOG);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mode_pend_ff <= `CTRL_MODE_RESET;
      mode_act_ff  <= `CTRL_MODE_RESET;
      src_ff       <= `SRC_ANALOG;
      gain_ff      <= `GAIN_RESET;
      tc_ff        <= `TC_RESET;
      rdata_ff     <= 16'h0000;
      st_ff        <= ST_IDLE;
      off_ff       <= 16'h0000;
      loaded_ff    <= 1'b0;
      nvwr_ff      <= 1'b0;
      acc_ff       <= '0;
      ncal_ff      <= '0;
      hold_ff      <= 24'h000000;
      active_ff    <= 1'b0;
    end else begin
      mode_pend_ff <= nxt_mode_pend;
      mode_act_ff  <= nxt_mode_act;
      src_ff       <= nxt_src;
      gain_ff      <= nxt_gain;
      tc_ff        <= nxt_tc;
      rdata_ff     <= nxt_rdata;
      st_ff        <= nxt_st;
      off_ff       <= nxt_off;
      loaded_ff    <= nxt_loaded;
      nvwr_ff      <= nxt_nvwr;
      acc_ff       <= nxt_acc;
      ncal_ff      <= nxt_ncal;
      hold_ff      <= nxt_hold;
      active_ff    <= nxt_active;
    end
  end

  // ****************************************
  // Offset, gain and lag filter datapath
  // ****************************************
  logic signed [16:0] diff;
  logic signed [HW-1:0] gain_num, gain_q;
  logic signed [39:0] filt_num, filt_q;
  logic          gdiv_busy, gdiv_done, fdiv_busy, fdiv_done;
  logic          gstart, fstart, torque_on;
  sample_type    x_ff, nxt_x, nxt_torque;
  logic signed [31:0] y_ff, nxt_y;
  logic [TW-1:0] tick_ff, nxt_tick;
  logic          tick, valid_ff, nxt_valid;

  // mV input scale assumes a plus/minus 10 V source
  // offset removed ahead of gain and filter
  assign diff     = 17'(i_adc_sample) - 17'(off_ff);
  // signed torque in 0.1 %, 100 % at gain x 0.1 V
  assign gain_num = HW'(diff) * signed'(`TORQUE_SCALE);
  assign gstart   = i_adc_valid && !gdiv_busy;
  assign tick     = (tick_ff == TW'(`FILT_TICK_CYC - 1));
  assign fstart   = tick && (tc_ff != 16'h0000) && !fdiv_busy;
  assign filt_num = 40'(signed'({x_ff, 16'h0000})) - 40'(y_ff);
  // torque only in mode 2 from the analog source
  assign torque_on = active_ff;

  always_comb begin
    nxt_x     = x_ff;
    nxt_y     = y_ff;
    nxt_valid = 1'b0;
    nxt_tick  = tick ? TW'(0) : tick_ff + TW'(1);
    if (gdiv_done)
      nxt_x = (gain_q > HW'(32767))  ? 16'h7fff :
              (gain_q < -HW'(32768)) ? 16'h8000 : gain_q[15:0];
    // step y by (x - y)/(tc + 1) each 0.01 ms
    if (tick && tc_ff == 16'h0000) begin
      nxt_y     = {x_ff, 16'h0000};
      nxt_valid = 1'b1;
    end else if (fdiv_done) begin
      nxt_y     = y_ff + filt_q[31:0];
      nxt_valid = 1'b1;
    end
    nxt_torque = torque_on ? nxt_y[31:16] : 16'h0000;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      x_ff      <= 16'h0000;
      y_ff      <= 32'h00000000;
      tick_ff   <= '0;
      valid_ff  <= 1'b0;
      torque_ff <= 16'h0000;
    end else begin
      x_ff      <= nxt_x;
      y_ff      <= nxt_y;
      tick_ff   <= nxt_tick;
      valid_ff  <= nxt_valid && torque_on;
      torque_ff <= nxt_torque;
    end
  end

  seq_divider #(.W(HW)) u_gain_div (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_start    (gstart),
    .i_num      (gain_num),
    .i_den      (HW'(gain_ff)),
    .o_busy     (gdiv_busy),
    .o_done     (gdiv_done),
    .o_quot     (gain_q)
  );

  // Slow filter update trades bandwidth for one sequential divide of its own
  seq_divider #(.W(40)) u_filt_div (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_start    (fstart),
    .i_num      (filt_num),
    .i_den      (40'(tc_ff) + 40'h1),
    .o_busy     (fdiv_busy),
    .o_done     (fdiv_done),
    .o_quot     (filt_q)
  );

  assign o_reg_rdata     = rdata_ff;
  assign o_nv_wr         = nvwr_ff;
  assign o_nv_data       = off_ff;
  assign o_torque_cmd    = torque_ff;
  assign o_torque_valid  = valid_ff;
  assign o_torque_active = active_ff;
  assign o_offset_shown  = st_ff[3];
  assign o_disp_offset   = off_ff;
endmodule

// file: torque_reference_conditioning_assertions.sv
// Port-level checks for the torque reference conditioning block.
// Assumes one clock domain and the map of torque_ref_defs.svh.
`timescale 1ns/1ps
`include "torque_ref_defs.svh"
module torque_reference_conditioning_assertions #(
  parameter int HOLD_CYCLES = 20
) (
  // Clock, reset and register port
  input wire logic                       i_core_clk,
  input wire logic                       i_sys_rst,
  input wire logic [7:0]                 i_reg_addr,
  input wire logic                       i_reg_rd,
  input wire logic [15:0]                o_reg_rdata,
  // Keys and outputs
  input wire logic                       i_key_mode,
  input wire logic                       o_nv_wr,
  input wire logic                       o_torque_valid,
  input wire logic                       o_torque_active,
  input wire logic                       o_offset_shown,
  input wire torque_ref_pkg::sample_type o_torque_cmd,
  input wire torque_ref_pkg::sample_type o_disp_offset
);
  import torque_ref_pkg::*;
  int unsigned key_cnt_ff;
  int unsigned nxt_key_cnt;

  // Raw cycles the mode key has been held
  always_comb begin
    nxt_key_cnt = i_key_mode ? key_cnt_ff + 1 : 0;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      key_cnt_ff <= 0;
    end else begin
      key_cnt_ff <= nxt_key_cnt;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_idle_cmd;
    !o_torque_active && !$past(o_torque_active) |->
      o_torque_cmd == 16'sh0000 && !o_torque_valid;
  endproperty
  a_idle_cmd: assert property (p_idle_cmd)
    else $error("torque output while inactive");
  property p_mode_status;
    i_reg_rd && i_reg_addr == 8'h18 && o_torque_active |=>
      o_reg_rdata[3:0] == 4'h2;
  endproperty
  a_mode_status: assert property (p_mode_status)
    else $error("active without torque mode");
  property p_state_onehot;
    i_reg_rd && i_reg_addr == 8'h18 |=> $onehot(o_reg_rdata[7:4]);
  endproperty
  a_state_onehot: assert property (p_state_onehot)
    else $error("offset state not one-hot");
  property p_shown_state;
    i_reg_rd && i_reg_addr == 8'h18 && o_offset_shown |=>
      o_reg_rdata[7:4] == 4'h8;
  endproperty
  a_shown_state: assert property (p_shown_state)
    else $error("offset shown outside edit");
  property p_shown_hold;
    $rose(o_offset_shown) |-> key_cnt_ff >= HOLD_CYCLES - 1;
  endproperty
  a_shown_hold: assert property (p_shown_hold)
    else $error("edit entered without full hold");
  property p_gain_range;
    i_reg_rd && i_reg_addr == 8'h08 |=>
      o_reg_rdata >= `GAIN_MIN && o_reg_rdata <= `GAIN_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range)
    else $error("gain out of range");
  property p_tc_range;
    i_reg_rd && i_reg_addr == 8'h0c |=> o_reg_rdata <= `TC_MAX;
  endproperty
  a_tc_range: assert property (p_tc_range)
    else $error("filter constant out of range");
  property p_disp_range;
    o_offset_shown |-> o_disp_offset >= $signed(`OFFSET_MIN) &&
      o_disp_offset <= $signed(`OFFSET_MAX);
  endproperty
  a_disp_range: assert property (p_disp_range)
    else $error("offset out of range");
  property p_valid_gap;
    o_torque_valid |=> (!o_torque_valid) [*8];
  endproperty
  a_valid_gap: assert property (p_valid_gap)
    else $error("filter updates too close");
  property p_nv_pulse;
    o_nv_wr |=> !o_nv_wr;
  endproperty
  a_nv_pulse: assert property (p_nv_pulse)
    else $error("store pulse too long");
endmodule

bind torque_reference_conditioning torque_reference_conditioning_assertions
  #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_key_mode(i_key_mode),
  .o_nv_wr(o_nv_wr), .o_torque_valid(o_torque_valid),
  .o_torque_active(o_torque_active), .o_offset_shown(o_offset_shown),
  .o_torque_cmd(o_torque_cmd), .o_disp_offset(o_disp_offset)
);

// file: torque_ref_host_model.sv
// Host controller analog torque output, already digitised in mV.
// Assumes the bench sets the wanted level on the core clock.
`timescale 1ns/1ps
module torque_ref_host_model #(
  parameter int GAP = 30
) (
  // Clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_sys_rst,
  // Wanted level
  input  wire torque_ref_pkg::sample_type i_level_mv,
  // Digitised reference
  output torque_ref_pkg::sample_type      o_adc_sample,
  output logic                            o_adc_valid
);
  import torque_ref_pkg::*;
  int         cnt_ff;
  sample_type lvl;

  assign lvl = (i_level_mv > 16'sh2710) ? 16'sh2710 :
               (i_level_mv < 16'shd8f0) ? 16'shd8f0 : i_level_mv;

  // Data only mean something beside the strobe; scrambled between
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_ff <= 0;
      o_adc_valid <= 1'b0;
      o_adc_sample <= 16'sh5a5a;
    end else begin
      cnt_ff <= (cnt_ff == GAP - 1) ? 0 : cnt_ff + 1;
      o_adc_valid <= (cnt_ff == 0);
      o_adc_sample <= (cnt_ff == 0) ? lvl : ~o_adc_sample;
    end
  end
endmodule

// file: torque_reference_conditioning_tb.sv
// Self-checking bench for torque reference conditioning.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "torque_ref_defs.svh"
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) begin \
      n_errors++; \
      $display("mismatch at %0t: got %h exp %h", $time, a, b); \
    end \
  end
module torque_reference_conditioning_tb;
  import torque_ref_pkg::*;
  typedef struct {int g; int lv; int ex;} row_type;
  localparam int HOLD = 20;
  logic        i_core_clk;
  logic        i_sys_rst;
  logic [7:0]  i_reg_addr;
  logic [15:0] i_reg_wdata;
  logic        i_reg_wr;
  logic        i_reg_rd;
  logic [15:0] o_reg_rdata;
  logic [3:0]  keys;
  logic        i_servo_on;
  logic        i_adc_valid;
  logic        o_nv_wr;
  logic        o_torque_valid;
  logic        o_torque_active;
  logic        o_offset_shown;
  sample_type  i_adc_sample;
  sample_type  level_mv;
  sample_type  i_nv_offset;
  sample_type  o_nv_data;
  sample_type  o_torque_cmd;
  sample_type  o_disp_offset;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  row_type     rows [6] = '{'{30, 3000, 1000}, '{30, 1000, 333},
    '{30, -1500, -500}, '{10, 10000, 10000}, '{100, -10000, -1000},
    '{10, -3, -3}};

  torque_ref_host_model host_u (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_level_mv(level_mv),
    .o_adc_sample(i_adc_sample), .o_adc_valid(i_adc_valid));
  torque_reference_conditioning #(.HOLD_CYCLES(HOLD)) dut_u (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_adc_sample(i_adc_sample), .i_adc_valid(i_adc_valid),
    .i_key_mode(keys[0]), .i_key_up(keys[1]), .i_key_down(keys[2]),
    .i_key_return(keys[3]), .i_servo_on(i_servo_on),
    .i_nv_offset(i_nv_offset), .o_nv_wr(o_nv_wr), .o_nv_data(o_nv_data),
    .o_torque_cmd(o_torque_cmd), .o_torque_valid(o_torque_valid),
    .o_torque_active(o_torque_active), .o_offset_shown(o_offset_shown),
    .o_disp_offset(o_disp_offset));

  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  // Run is about 3500 cycles; ceiling leaves ample margin
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up;
    end
  end

  task wrap_up;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task do_reset;
    @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    repeat (12) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_core_clk);
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    @(negedge i_core_clk);
  endtask
  task rdchk(input logic [7:0] a, input logic [15:0] m, e);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_core_clk);
    `CHK(o_reg_rdata & m, e)
  endtask
  task set_level(input sample_type v);
    @(posedge i_core_clk);
    level_mv <= v;
  endtask
  task wait_valid(input int n);
    for (int k = 0; k < 600 && n > 0; k++) begin
      @(negedge i_core_clk);
      if (o_torque_valid === 1'b1) n--;
    end
    `CHK(n, 0)
  endtask
  task wait_nv;
    for (int k = 0; k < 3000; k++) begin
      @(negedge i_core_clk);
      if (o_nv_wr === 1'b1) break;
    end
    `CHK(o_nv_wr, 1'b1)
  endtask
  task press(input int idx, input int len);
    @(posedge i_core_clk);
    keys[idx] <= 1'b1;
    repeat (len) @(posedge i_core_clk);
    keys[idx] <= 1'b0;
    repeat (6) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask

  initial begin
    i_sys_rst <= 1'b1;
    i_reg_addr <= 8'h00;
    i_reg_wdata <= 16'h0000;
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
    keys <= 4'h0;
    i_servo_on <= 1'b0;
    level_mv <= 16'sh0000;
    i_nv_offset <= 16'sh0000;
    do_reset;
    rdchk(`REG_GAIN, 16'hffff, `GAIN_RESET);
    rdchk(`REG_FILTER_TC, 16'hffff, `TC_RESET);
    rdchk(8'h20, 16'hffff, 16'h0000);
    wr(`REG_GAIN, 16'h0005);
    rdchk(`REG_GAIN, 16'hffff, `GAIN_MIN);
    wr(`REG_GAIN, 16'h00c8);
    rdchk(`REG_GAIN, 16'hffff, `GAIN_MAX);
    wr(`REG_FILTER_TC, 16'h0bb8);
    rdchk(`REG_FILTER_TC, 16'hffff, `TC_MAX);
    wr(`REG_CTRL_MODE, 16'h0002);
    `CHK(o_torque_active, 1'b0)
    wr(`REG_FUNCTION, {8'h00, `FN_RESTART});
    `CHK(o_torque_active, 1'b1)
    wr(`REG_FILTER_TC, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(`REG_GAIN, 16'(rows[i].g));
      set_level(sample_type'(rows[i].lv));
      wait_valid(3);
      `CHK(o_torque_cmd, sample_type'(rows[i].ex))
    end
    wr(`REG_SRC_SELECT, 16'h0001);
    `CHK(o_torque_active, 1'b0)
    repeat (150) @(negedge i_core_clk);
    `CHK(o_torque_cmd, 16'sh0000)
    wr(`REG_SRC_SELECT, 16'h0000);
    wr(`REG_GAIN, 16'h001e);
    set_level(16'sh0000);
    wait_valid(3);
    wr(`REG_FILTER_TC, `TC_RESET);
    set_level(16'sh0bb8);
    wait_valid(3);
    `CHK(o_torque_cmd > 0 && o_torque_cmd < 16'sh01f4, 1'b1)
    wr(`REG_FILTER_TC, 16'h0000);
    set_level(16'sh0028);
    wr(`REG_FUNCTION, {8'h00, `FN_AUTO_OFFSET});
    rdchk(`REG_STATUS, 16'h00f0, 16'h0020);
    wait_nv;
    `CHK(o_nv_data, 16'sh0028)
    wr(`REG_GAIN, 16'h000a);
    set_level(16'sh008c);
    wait_valid(3);
    `CHK(o_torque_cmd, 16'sh0064)
    // servo on for the manual edit
    @(posedge i_core_clk);
    i_servo_on <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    wr(`REG_FUNCTION, {8'h00, `FN_AUTO_OFFSET});
    rdchk(`REG_STATUS, 16'h00f0, 16'h0010);
    wr(`REG_FUNCTION, {8'h00, `FN_RESTORE});
    rdchk(`REG_OFFSET, 16'hffff, 16'h0028);
    rdchk(`REG_GAIN, 16'hffff, `GAIN_RESET);
    wr(`REG_FUNCTION, {8'h00, `FN_MANUAL_OFFSET});
    rdchk(`REG_STATUS, 16'h00f0, 16'h0040);
    press(0, HOLD / 2);
    `CHK(o_offset_shown, 1'b0)
    press(0, HOLD + 10);
    `CHK(o_offset_shown, 1'b1)
    `CHK(o_disp_offset, 16'sh0028)
    repeat (3) press(1, 4);
    press(2, 4);
    `CHK(o_disp_offset, 16'sh002a)
    @(posedge i_core_clk);
    keys[3] <= 1'b1;
    wait_nv;
    `CHK(o_nv_data, 16'sh002a)
    @(posedge i_core_clk);
    keys[3] <= 1'b0;
    @(negedge i_core_clk);
    `CHK(o_offset_shown, 1'b0)
    press(3, 2);
    rdchk(`REG_STATUS, 16'h00f0, 16'h0010);
    wr(`REG_FUNCTION, {8'h00, `FN_MANUAL_OFFSET});
    wr(`REG_FUNCTION, {8'h00, `FN_EXIT});
    rdchk(`REG_STATUS, 16'h00f0, 16'h0010);
    // Saved offset beyond the edit range
    @(posedge i_core_clk);
    i_nv_offset <= 16'shf830;
    do_reset;
    rdchk(`REG_OFFSET, 16'hffff, `OFFSET_MIN);
    `CHK(o_torque_active, 1'b0)
    wrap_up;
  end
endmodule
